// ---- hdl/twm_master_rx.sv ----
// two-wire master receiver with APB register access
// What this block does
// - start condition only once bus is free
// - start sent sets flag, status 0x08
// - address direction bit picks receive or transmit
// - after read address: status 0x38/0x40/0x48
// - received byte readable when flag rises
// - repeated start reports 0x10, keeps the bus
// - in 0x40 ack_enable picks 0x50 or 0x58
// - in 0x58 repeated start, stop, or both
// - in 0x48 repeated start, stop, or both
// - arbitration lost: release or restart when free
// - in 0x10 write address switches to transmit
// - stop_request clears itself after stop sent
// - lost and addressed: slave codes 68/78/b0
// - data write with flag low sets collision
//
// Local design decisions: the APB register port and the address map.
`timescale 1ns/100ps
module twm_master_rx
  import twm_pkg::*;
#(
  parameter int SCL_HALF = SCL_HALF_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe
);
  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  // codes in which this end is not bus master and lets go of the clock once the flag clears
  function automatic logic not_master(input logic [7:0] c);
    not_master = (c == ST_ARB) || (c == ST_SL_W) || (c == ST_SL_GC) || (c == ST_SL_R);
  endfunction : not_master

  function automatic logic [7:0] byte_code(input logic addr, input logic rd, input logic ack);
    if (addr && rd) byte_code = ack ? ST_RA_ACK : ST_RA_NACK;
    else if (addr) byte_code = ack ? ST_WA_ACK : ST_WA_NACK;
    else if (rd) byte_code = ack ? ST_RD_ACK : ST_RD_NACK;
    else byte_code = ack ? ST_TD_ACK : ST_TD_NACK;
  endfunction : byte_code

  // ----------------------------------------------------------------
  // pin synchronisers and bus watch
  // ----------------------------------------------------------------
  logic scl_s, sda_s, scl_p_r, sda_p_r, busy_r;
  twm_sync #(.W(2)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d({scl_in, sda_in}),
    .q({scl_s, sda_s})
  );
  wire start_det = scl_s && sda_p_r && !sda_s;
  wire stop_det = scl_s && !sda_p_r && sda_s;
  wire scl_rise = scl_s && !scl_p_r;
  wire scl_fall = !scl_s && scl_p_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_p_r <= 1'b1;
      sda_p_r <= 1'b1;
      busy_r <= 1'b0;
    end else begin
      scl_p_r <= scl_s;
      sda_p_r <= sda_s;
      if (start_det) busy_r <= 1'b1;
      else if (stop_det) busy_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  logic flag_r, ack_r, sta_r, sto_r, wc_r, en_r, ie_r;
  logic [7:0] data_r, own_r, code_r;
  logic [31:0] prdata_r;
  wire wr_en = psel && penable && pwrite;
  wire hit_ctl = (paddr == OFS_CONTROL);
  wire hit_sts = (paddr == OFS_STATUS);
  wire hit_dat = (paddr == OFS_DATA);
  wire hit_own = (paddr == OFS_OWN);
  wire hit = hit_ctl || hit_sts || hit_dat || hit_own;
  wire ctl_wr = wr_en && hit_ctl;
  wire dat_wr = wr_en && hit_dat;
  wire flag_clr = ctl_wr && pwdata[CB_FLAG];
  wire [7:0] ctl_rd = {flag_r, ack_r, sta_r, sto_r, wc_r, en_r, 1'b0, ie_r};
  // prescaler field does not exist here, so the low three bits read zero
  wire [7:0] sts_rd = {code_r[7:3], 3'b000};
  wire [7:0] rd_mux = hit_ctl ? ctl_rd : hit_sts ? sts_rd : hit_dat ? data_r :
                      hit_own ? own_r : 8'h00;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign prdata = prdata_r;
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {ack_r, sta_r, en_r, ie_r} <= 4'h0;
      own_r <= OWN_RST;
      prdata_r <= 32'h0000_0000;
    end else begin
      if (psel && !penable) prdata_r <= {24'h00_0000, rd_mux};
      if (ctl_wr) begin
        ack_r <= pwdata[CB_ACK];
        sta_r <= pwdata[CB_STA];
        en_r <= pwdata[CB_EN];
        ie_r <= pwdata[CB_IE];
      end
      if (wr_en && hit_own) own_r <= pwdata[7:0];
    end
  end

  // ----------------------------------------------------------------
  // bus engine
  // ----------------------------------------------------------------
  twm_state_t state_r;
  logic [15:0] cnt_r;
  logic [3:0] bit_r;
  logic [7:0] shift_r;
  logic addr_ph_r, rd_r, ackd_r, rs_r, scl_oe_r, sda_oe_r;
  wire cnt_done = (cnt_r == 16'(SCL_HALF - 1));
  wire hi_done = (state_r == S_BIT_HI) && scl_s && cnt_done;
  // bits this end sends: address and written data bits, or its own ack slot
  wire intent = (bit_r < 4'd8) ? (addr_ph_r || !rd_r) : (rd_r && !addr_ph_r);
  wire tx_low = (bit_r < 4'd8) ? (intent && !shift_r[7]) : (intent && ackd_r);
  wire lost = intent && !sda_oe_r && !sda_s;
  wire byte_end = hi_done && !lost && (bit_r == 4'd8);
  wire gcall = (shift_r[7:1] == 7'h00) && own_r[0];
  wire match = ack_r && ((shift_r[7:1] == own_r[7:1]) || gcall);
  wire [7:0] slv_code = gcall ? ST_SL_GC : shift_r[0] ? ST_SL_R : ST_SL_W;
  assign scl_oe = scl_oe_r;
  assign sda_oe = sda_oe_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= S_IDLE;
      cnt_r <= 16'h0000;
      bit_r <= 4'h0;
      shift_r <= 8'h00;
      {addr_ph_r, rd_r, ackd_r, rs_r, scl_oe_r, sda_oe_r} <= 6'h00;
      {flag_r, sto_r, wc_r} <= 3'h0;
      data_r <= DATA_RST;
      code_r <= ST_NONE;
    end else begin
      cnt_r <= cnt_done ? 16'h0000 : cnt_r + 16'h0001;
      if (flag_clr) flag_r <= 1'b0;
      if (ctl_wr) sto_r <= pwdata[CB_STO];
      if (dat_wr) wc_r <= !flag_r;
      if (dat_wr && flag_r) data_r <= pwdata[7:0];
      unique case (state_r)
        S_IDLE: begin
          cnt_r <= 16'h0000;
          {scl_oe_r, sda_oe_r, rs_r} <= 3'b000;
          if (sta_r && !flag_r) state_r <= S_WAIT_FREE;
        end
        S_WAIT_FREE: begin
          cnt_r <= 16'h0000;
          // a start after a free bus is a fresh one, never a repeated one
          rs_r <= 1'b0;
          if (!busy_r && scl_s && sda_s) begin
            sda_oe_r <= 1'b1;
            state_r <= S_START;
          end
        end
        S_START: if (cnt_done) begin
          scl_oe_r <= 1'b1;
          flag_r <= 1'b1;
          code_r <= rs_r ? ST_RSTART : ST_START;
          addr_ph_r <= 1'b1;
          state_r <= S_HOLD;
        end
        S_HOLD: begin
          // the clock stays where the entry left it: low while master
          cnt_r <= 16'h0000;
          sda_oe_r <= 1'b0;
          if (!flag_r) begin
            code_r <= ST_NONE;
            ackd_r <= ack_r;
            if (not_master(code_r)) begin
              scl_oe_r <= 1'b0;
              state_r <= (code_r == ST_ARB && sta_r) ? S_WAIT_FREE : S_IDLE;
            end else if (sto_r) begin
              sda_oe_r <= 1'b1;
              state_r <= S_STOP_LO;
            end else if (sta_r) begin
              state_r <= S_RS_LO;
            end else begin
              bit_r <= 4'h0;
              state_r <= S_BIT_LO;
              if (addr_ph_r) begin
                shift_r <= data_r;
                rd_r <= data_r[0];
              end else begin
                shift_r <= rd_r ? 8'hff : data_r;
              end
            end
          end
        end
        S_RS_LO: if (cnt_done) begin
          scl_oe_r <= 1'b0;
          state_r <= S_RS_HI;
        end
        S_RS_HI: begin
          if (!scl_s) cnt_r <= 16'h0000;
          else if (cnt_done) begin
            sda_oe_r <= 1'b1;
            rs_r <= 1'b1;
            state_r <= S_START;
          end
        end
        S_BIT_LO: begin
          sda_oe_r <= tx_low;
          if (cnt_done) begin
            scl_oe_r <= 1'b0;
            state_r <= S_BIT_HI;
          end
        end
        S_BIT_HI: begin
          if (!scl_s) cnt_r <= 16'h0000;
          else if (cnt_done && lost) begin
            {scl_oe_r, sda_oe_r} <= 2'b00;
            if (addr_ph_r && bit_r < 4'd8) begin
              // keep listening: another master may be calling us
              shift_r <= {shift_r[6:0], sda_s};
              bit_r <= bit_r + 4'h1;
              state_r <= S_FOLLOW;
            end else begin
              flag_r <= 1'b1;
              code_r <= ST_ARB;
              state_r <= S_HOLD;
            end
          end else if (cnt_done) begin
            scl_oe_r <= 1'b1;
            if (bit_r < 4'd8) begin
              shift_r <= {shift_r[6:0], sda_s};
              bit_r <= bit_r + 4'h1;
              state_r <= S_BIT_LO;
            end else begin
              flag_r <= 1'b1;
              code_r <= byte_code(addr_ph_r, rd_r, rd_r && !addr_ph_r ? ackd_r : !sda_s);
              if (rd_r && !addr_ph_r) data_r <= shift_r;
              // the address is spent, so later bytes run as data
              addr_ph_r <= 1'b0;
              state_r <= S_HOLD;
            end
          end
        end
        S_STOP_LO: if (cnt_done) begin
          scl_oe_r <= 1'b0;
          state_r <= S_STOP_HI;
        end
        S_STOP_HI: begin
          if (!scl_s) cnt_r <= 16'h0000;
          else if (cnt_done) begin
            sda_oe_r <= 1'b0;
            sto_r <= 1'b0;
            rs_r <= 1'b0;
            state_r <= sta_r ? S_WAIT_FREE : S_IDLE;
          end
        end
        S_FOLLOW: begin
          cnt_r <= 16'h0000;
          if (scl_rise && bit_r < 4'd8) begin
            shift_r <= {shift_r[6:0], sda_s};
            bit_r <= bit_r + 4'h1;
          end else if (scl_fall && bit_r == 4'd8) begin
            bit_r <= 4'h9;
            if (match) sda_oe_r <= 1'b1;
            else begin
              flag_r <= 1'b1;
              code_r <= ST_ARB;
              state_r <= S_HOLD;
            end
          end else if (scl_fall && bit_r == 4'd9) begin
            scl_oe_r <= 1'b1;
            flag_r <= 1'b1;
            code_r <= slv_code;
            state_r <= S_HOLD;
          end
        end
      endcase
      // disabling drops the bus at once
      if (!en_r) begin
        state_r <= S_IDLE;
        {scl_oe_r, sda_oe_r} <= 2'b00;
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence rs_done_s;
    state_r == S_RS_HI && scl_s && cnt_done && en_r;
  endsequence
  sequence stop_done_s;
    state_r == S_STOP_HI && scl_s && cnt_done && en_r;
  endsequence
  sequence rd_byte_s;
    byte_end && en_r && rd_r && !addr_ph_r;
  endsequence

  free_bus_a: assert property ((state_r == S_WAIT_FREE && busy_r) |=> state_r != S_START)
    else $error("start issued on a busy bus");
  start_code_a: assert property ((state_r == S_START && cnt_done && !rs_r && en_r)
    |=> flag_r && code_r == ST_START && scl_oe_r)
    else $error("start did not report 0x08");
  mode_sel_a: assert property ((byte_end && en_r && addr_ph_r && !rd_r)
    |=> code_r == ST_WA_ACK || code_r == ST_WA_NACK)
    else $error("write address gave a receive code");
  read_addr_a: assert property ((byte_end && en_r && addr_ph_r && rd_r)
    |=> flag_r && (code_r == ST_RA_ACK || code_r == ST_RA_NACK))
    else $error("read address gave a wrong code");
  data_cap_a: assert property (rd_byte_s |=> data_r == $past(shift_r) && flag_r)
    else $error("received byte not in data register");
  ack_code_a: assert property (rd_byte_s |=> code_r == ($past(ackd_r) ? ST_RD_ACK : ST_RD_NACK))
    else $error("data byte code does not follow ack choice");
  rs_code_a: assert property (rs_done_s ##1 (state_r == S_START) [*1] |->
    ##[1:1000] (flag_r && code_r == ST_RSTART) || !en_r)
    else $error("repeated start did not report 0x10");
  stop_clr_a: assert property (stop_done_s |=> !sto_r && !sda_oe_r && !scl_oe_r)
    else $error("stop request not cleared after stop");
  collision_a: assert property ((dat_wr && !flag_r) |=> wc_r &&
    (data_r == $past(data_r) || $past(byte_end)))
    else $error("write collision not flagged");
  stretch_a: assert property ((flag_r && state_r == S_HOLD && !not_master(code_r) && en_r)
    |-> scl_oe_r)
    else $error("clock released while flag is set");
  arb_free_a: assert property ((state_r == S_HOLD && code_r == ST_ARB && !flag_r && !sta_r
    && en_r) |=> state_r == S_IDLE && !scl_oe_r)
    else $error("bus not released after lost arbitration");
endmodule : twm_master_rx

// ---- hdl/twm_pkg.sv ----
// package: register map, control fields, status codes and timing of the two-wire master receiver
package twm_pkg;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int SCL_HALF_NS = 5000;
  // a least time, so the count rounds up
  localparam int SCL_HALF_CYC = (SCL_HALF_NS * CLK_MHZ + 999) / 1000;
  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] OFS_CONTROL = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h004;
  localparam logic [11:0] OFS_DATA = 12'h008;
  localparam logic [11:0] OFS_OWN = 12'h00c;
  // serial_control field positions
  localparam int CB_FLAG = 7;
  localparam int CB_ACK = 6;
  localparam int CB_STA = 5;
  localparam int CB_STO = 4;
  localparam int CB_WC = 3;
  localparam int CB_EN = 2;
  localparam int CB_IE = 0;
  // values after reset
  localparam logic [7:0] DATA_RST = 8'hff;
  localparam logic [7:0] OWN_RST = 8'h00;
  // ----------------------------------------------------------------
  // status codes
  // ----------------------------------------------------------------
  localparam logic [7:0] ST_START = 8'h08;
  localparam logic [7:0] ST_RSTART = 8'h10;
  localparam logic [7:0] ST_WA_ACK = 8'h18;
  localparam logic [7:0] ST_WA_NACK = 8'h20;
  localparam logic [7:0] ST_TD_ACK = 8'h28;
  localparam logic [7:0] ST_TD_NACK = 8'h30;
  localparam logic [7:0] ST_ARB = 8'h38;
  localparam logic [7:0] ST_RA_ACK = 8'h40;
  localparam logic [7:0] ST_RA_NACK = 8'h48;
  localparam logic [7:0] ST_RD_ACK = 8'h50;
  localparam logic [7:0] ST_RD_NACK = 8'h58;
  localparam logic [7:0] ST_SL_W = 8'h68;
  localparam logic [7:0] ST_SL_GC = 8'h78;
  localparam logic [7:0] ST_SL_R = 8'hb0;
  localparam logic [7:0] ST_NONE = 8'hf8;
  // ----------------------------------------------------------------
  // bus engine states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    S_IDLE, S_WAIT_FREE, S_START, S_HOLD, S_RS_LO, S_RS_HI,
    S_BIT_LO, S_BIT_HI, S_STOP_LO, S_STOP_HI, S_FOLLOW
  } twm_state_t;
endpackage : twm_pkg

// ---- hdl/twm_sync.sv ----
// two flip-flop synchroniser for the bus pins
`timescale 1ns/100ps
module twm_sync #(
  parameter int W = 2
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  // idle bus lines are high, so both stages reset high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= '1;
      q <= '1;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule : twm_sync

// ---- verification/test_twowire_master_receiver.sv ----
// self-checking bench for the two-wire master receiver
`timescale 1ns/100ps
module test_twowire_master_receiver
  import twm_pkg::*;
;
  localparam logic [6:0] SLV = 7'h2a;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, scl_out, scl_oe, sda_out, sda_oe, s_scl_oe, s_sda_oe;
  // open-drain wires with pull-up
  wire logic scl = ~s_scl_oe & (scl_oe ? scl_out : 1'b1);
  wire logic sda = ~s_sda_oe & (sda_oe ? sda_out : 1'b1);
  int fail_count = 0;
  int checks = 0;
  logic [7:0] exp_q[$];
  always #5 pclk = ~pclk;
  twm_master_rx #(.SCL_HALF(6)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .scl_in(scl), .scl_out(scl_out), .scl_oe(scl_oe),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe));
  twm_slave_model #(.ADDR(SLV)) slave (.scl(scl), .sda(sda), .scl_oe(s_scl_oe),
    .sda_oe(s_sda_oe));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input string name);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    check(name, r, exp);
  endtask : rd_chk
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, {24'h0, d}, r, e);
  endtask : wr
  task automatic ctl(input logic [7:0] d);
    wr(OFS_CONTROL, d);
  endtask : ctl
  // bounded poll of one control bit; running out counts as a mismatch
  task automatic poll(input int b, input logic v);
    logic [31:0] r;
    logic e;
    int n;
    for (n = 0; n < 500; n++) begin
      apb(1'b0, OFS_CONTROL, 32'h0, r, e);
      if (r[b] === v) break;
    end
    if (n == 500) begin
      fail_count++;
      $display("ERROR control poll expected %h seen %h", v, r[b]);
    end
  endtask : poll
  task automatic st(input logic [7:0] code);
    poll(CB_FLAG, 1'b1);
    rd_chk(OFS_STATUS, {24'h0, code}, "status");
  endtask : st
  task automatic finish_test();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : finish_test
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] r;
    logic e;
    int n;
    logic ack;
    r = $urandom(32'hd897d551);
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(OFS_CONTROL, 32'h00, "control");
    rd_chk(OFS_STATUS, 32'hf8, "status");
    rd_chk(OFS_DATA, 32'hff, "data");
    rd_chk(OFS_OWN, 32'h00, "own address");
    apb(1'b0, 12'h010, 32'h0, r, e);
    check("unmapped read", r, 32'h0);
    check("unmapped error", {31'h0, e}, 32'h1);
    wr(OFS_DATA, 8'h55);
    rd_chk(OFS_CONTROL, 32'h08, "collision");
    rd_chk(OFS_DATA, 32'hff, "discarded data");
    ctl(8'ha4);
    st(ST_START);
    check("scl held", {31'h0, scl}, 32'h0);
    for (int rnd = 0; rnd < 2; rnd++) begin
      slave.stretch = rnd * 300;
      n = $urandom_range(4, 1);
      // the slave fetches its first byte at the address ack, before the flag is seen
      for (int i = 0; i < n; i++) begin
        exp_q.push_back(8'($urandom));
        slave.tx_q.push_back(exp_q[i]);
      end
      wr(OFS_DATA, {SLV, 1'b1});
      ctl(8'h84);
      st(ST_RA_ACK);
      for (int i = 0; i < n; i++) begin
        ack = (i < n - 1);
        ctl(ack ? 8'hc4 : 8'h84);
        st(ack ? ST_RD_ACK : ST_RD_NACK);
        rd_chk(OFS_DATA, {24'h0, exp_q.pop_front()}, "data");
      end
      check("master nack", {31'h0, slave.last_ack}, 32'h1);
      ctl(rnd ? 8'ha4 : 8'hb4);
      st(rnd ? ST_RSTART : ST_START);
      if (rnd == 0) rd_chk(OFS_CONTROL, 32'ha4, "stop cleared");
    end
    // another party keeps the ack slot low, so the final nack loses the bus
    slave.tx_q.push_back(8'($urandom));
    wr(OFS_DATA, {SLV, 1'b1});
    ctl(8'h84);
    st(ST_RA_ACK);
    slave.hog = 1'b1;
    ctl(8'h84);
    st(ST_ARB);
    check("scl released", {31'h0, scl}, 32'h1);
    ctl(8'ha4);
    repeat (50) @(posedge pclk);
    rd_chk(OFS_CONTROL, 32'h24, "start held");
    slave.hog = 1'b0;
    st(ST_START);
    wr(OFS_DATA, {~SLV, 1'b1});
    ctl(8'h84);
    st(ST_RA_NACK);
    ctl(8'ha4);
    st(ST_RSTART);
    wr(OFS_DATA, {SLV, 1'b0});
    ctl(8'h84);
    st(ST_WA_ACK);
    ctl(8'h94);
    poll(CB_STO, 1'b0);
    check("scl idle", {31'h0, scl}, 32'h1);
    check("sda idle", {31'h0, sda}, 32'h1);
    finish_test();
  end
  initial begin
    #400000;
    fail_count++;
    $display("ERROR watchdog expected done seen timeout");
    finish_test();
  end
endmodule : test_twowire_master_receiver

// ---- verification/twm_slave_model.sv ----
// slave transmitter model on the far side of the two-wire bus
`timescale 1ns/100ps
module twm_slave_model #(
  parameter logic [6:0] ADDR = 7'h2a
) (
  input wire logic scl,
  input wire logic sda,
  output logic scl_oe,
  output logic sda_oe
);
  logic [7:0] tx_q[$];
  logic last_ack;
  int stretch;
  bit got_stop;
  bit hog;
  // ----------------------------------------------------------------
  // one addressed transfer
  // ----------------------------------------------------------------
  task automatic serve();
    logic [7:0] b;
    logic [7:0] d;
    for (int i = 0; i < 8; i++) begin
      @(posedge scl);
      b = {b[6:0], sda};
    end
    @(negedge scl);
    if (b[7:1] != ADDR) wait (0);
    sda_oe = 1'b1;
    // slow answer: keep the clock low past the master's own low time
    if (stretch > 0) begin
      scl_oe = 1'b1;
      #(stretch);
      scl_oe = 1'b0;
    end
    @(negedge scl);
    sda_oe = 1'b0;
    if (!b[0]) wait (0);
    forever begin
      d = (tx_q.size() > 0) ? tx_q.pop_front() : 8'hff;
      for (int i = 7; i >= 0; i--) begin
        sda_oe = ~d[i];
        @(negedge scl);
      end
      // released after the last bit unless a busy party keeps the ack slot low
      sda_oe = hog;
      @(posedge scl);
      last_ack = sda;
      wait (!hog);
      sda_oe = 1'b0;
      if (sda) wait (0);
      @(negedge scl);
    end
  endtask : serve
  // ----------------------------------------------------------------
  // framing: start, repeated start and stop end the transfer
  // ----------------------------------------------------------------
  initial begin
    scl_oe = 1'b0;
    sda_oe = 1'b0;
    stretch = 0;
    last_ack = 1'b0;
    hog = 1'b0;
    forever begin
      @(negedge sda iff scl === 1'b1);
      do begin
        got_stop = 1'b0;
        fork : xfer
          serve();
          @(negedge sda iff scl === 1'b1);
          begin
            @(posedge sda iff scl === 1'b1);
            got_stop = 1'b1;
          end
        join_any
        disable xfer;
        sda_oe = 1'b0;
        scl_oe = 1'b0;
      end while (!got_stop);
    end
  end
endmodule : twm_slave_model
